//--- logic/modulo_timer_pkg.sv
// What this block does
// - 8-bit up-counter runs free or wraps at a programmable modulo limit.
// - Overflow interrupt can be enabled or disabled by a control bit.
// - Writing one to status/control bit 5 resets the counter; reads zero.
// - Status/control bit 4 halts counting while set, counting while clear.
// - Prescaler source: bus clock, fixed clock rise, or pin rise or fall.
// - Prescaler divides by 1, 2, 4, 8, 16, 32, 64, 128 or 256.
// - Timer keeps counting in wait mode; its interrupt can wake the processor.
// - Timer is disabled in every stop mode and never wakes from stop.
// - Deep stop wake, or light stop left by reset, returns the reset state.
// - Light stop left by interrupt keeps state; counter resumes from its value.
// - Counting is suspended during active debug and resumes from that value.
// - Counter reset write or modulo write resets the counter.
// - Status/control: flag bit 7, enable bit 6, reset bit 5, halt bit 4.
// - Clock config: source select bits 5:4, prescale bits 3:0, 7:6 zero.
// - Counter register reads the present count.
// - Modulo register is read/write and holds the wrap limit.
package modulo_timer_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CLOCK_CONFIG = 4'h4;
    localparam logic [3:0] ADDR_COUNT_VALUE = 4'h8;
    localparam logic [3:0] ADDR_MODULO_LIMIT = 4'hc;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int OVERFLOW_FLAG_BIT = 7;
    localparam int OVERFLOW_IRQ_EN_BIT = 6;
    localparam int COUNTER_RESET_BIT = 5;
    localparam int COUNTER_HALT_BIT = 4;
    localparam int CLOCK_SOURCE_LSB = 4;
    localparam int CLOCK_SOURCE_MSB = 5;
    localparam int PRESCALE_LSB = 0;
    localparam int PRESCALE_MSB = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic RESET_HALT = 1'h1;
    localparam logic RESET_IRQ_EN = 1'h0;
    localparam logic [1:0] RESET_CLOCK_SOURCE = 2'h0;
    localparam logic [3:0] RESET_PRESCALE = 4'h0;
    localparam logic [7:0] RESET_COUNT = 8'h00;
    localparam logic [7:0] RESET_WRAP_LIMIT = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // ----------------------------------------
    // Clock source encodings
    // ----------------------------------------
    localparam logic [1:0] SRC_BUS_CLOCK = 2'h0;
    localparam logic [1:0] SRC_FIXED_RISE = 2'h1;
    localparam logic [1:0] SRC_PIN_RISE = 2'h2;
    localparam logic [1:0] SRC_PIN_FALL = 2'h3;

    // Largest prescale code that divides; codes above it divide by 256
    localparam logic [3:0] PRESCALE_MAX = 4'h8;

endpackage : modulo_timer_pkg

//--- logic/timer_prescaler.sv
module timer_prescaler
    import modulo_timer_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic clear_in,
    input wire logic enable_in,
    input wire logic [1:0] clock_source_sel_in,
    input wire logic [3:0] prescale_sel_in,
    input wire logic fixed_freq_clock_in,
    input wire logic ext_timer_clock_pin_in,
    output logic tick_out
);

    // Refused at elaboration: the mask logic only serves an 8-bit divider
    if (DIV_WIDTH != 8) begin : g_width_check
        $error("timer_prescaler supports only an 8-bit divider");
    end

    logic fixed_prev;
    logic pin_prev;
    logic source_event;
    logic [DIV_WIDTH-1:0] div_count;
    logic [DIV_WIDTH-1:0] div_mask;

    // ----------------------------------------
    // Source edge selection
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            fixed_prev <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            fixed_prev <= fixed_freq_clock_in;
            pin_prev <= ext_timer_clock_pin_in;
        end
    end

    always_comb begin
        unique case (clock_source_sel_in)
            SRC_BUS_CLOCK: source_event = 1'b1;
            SRC_FIXED_RISE: source_event = fixed_freq_clock_in && !fixed_prev;
            SRC_PIN_RISE: source_event = ext_timer_clock_pin_in && !pin_prev;
            SRC_PIN_FALL: source_event = !ext_timer_clock_pin_in && pin_prev;
        endcase
    end

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    // Mask of 2^n - 1; codes above eight saturate at divide by 256
    always_comb begin
        if (prescale_sel_in >= PRESCALE_MAX) begin
            div_mask = '1;
        end else begin
            div_mask = DIV_WIDTH'((9'h001 << prescale_sel_in) - 9'h001);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || clear_in) begin
            div_count <= '0;
            tick_out <= 1'b0;
        end else if (enable_in && source_event) begin
            if ((div_count & div_mask) == div_mask) begin
                div_count <= '0;
                tick_out <= 1'b1;
            end else begin
                div_count <= div_count + 1'b1;
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end

endmodule : timer_prescaler

//--- logic/modulo_timer.sv
// Our own choices: the AHB-Lite slave port and the register offsets.
module modulo_timer
    import modulo_timer_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // Timer clock sources and power modes
    input wire logic fixed_freq_clock_in,
    input wire logic ext_timer_clock_pin_in,
    input wire logic stop_mode_in,
    input wire logic stop_reset_wake_in,
    input wire logic debug_active_in,
    output logic irq_out,
    output logic [7:0] count_value_out
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic overflow_flag;
    logic overflow_irq_en;
    logic counter_halt_ctl;
    logic [1:0] clock_source_sel;
    logic [3:0] prescale_sel;
    logic [7:0] count_value;
    logic [7:0] wrap_limit;
    logic clear_armed;
    logic soft_reset;
    logic wr_pending;
    logic [3:0] wr_addr;
    logic addr_phase;
    logic [3:0] bus_addr;
    logic wr_status;
    logic wr_clock;
    logic wr_modulo;
    logic counter_clear;
    logic count_enable;
    logic tick;
    logic wrap_now;
    logic next_flag_set;
    logic flag_clear;
    logic next_flag;
    logic next_irq_en;
    logic [7:0] wdata;

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    function automatic logic [7:0] read_reg(input logic [3:0] addr);
        logic [7:0] value;
        value = 8'h00;
        unique case (addr)
            ADDR_STATUS_CONTROL: begin
                // Reset bit and low nibble read zero
                value[OVERFLOW_FLAG_BIT] = overflow_flag;
                value[OVERFLOW_IRQ_EN_BIT] = overflow_irq_en;
                value[COUNTER_RESET_BIT] = 1'b0;
                value[COUNTER_HALT_BIT] = counter_halt_ctl;
            end
            ADDR_CLOCK_CONFIG: begin
                value[CLOCK_SOURCE_MSB:CLOCK_SOURCE_LSB] = clock_source_sel;
                value[PRESCALE_MSB:PRESCALE_LSB] = prescale_sel;
            end
            ADDR_COUNT_VALUE: value = count_value;
            ADDR_MODULO_LIMIT: value = wrap_limit;
            default: value = 8'h00;
        endcase
        return value;
    endfunction : read_reg

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // Zero wait states: every access completes in its first data cycle
    assign addr_phase = hsel_in && htrans_in[1] && hready_in;
    assign bus_addr = {haddr_in[3:2], 2'b00};
    assign wdata = hwdata_in[7:0];
    assign wr_status = wr_pending && (wr_addr == ADDR_STATUS_CONTROL);
    assign wr_clock = wr_pending && (wr_addr == ADDR_CLOCK_CONFIG);
    assign wr_modulo = wr_pending && (wr_addr == ADDR_MODULO_LIMIT);

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end

    // Unmapped addresses read zero and ignore writes
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            wr_pending <= 1'b0;
            wr_addr <= 4'h0;
        end else begin
            wr_pending <= addr_phase && hwrite_in && (haddr_in[31:4] == 28'h0000000);
            wr_addr <= bus_addr;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            hrdata_out <= 32'h00000000;
        end else if (addr_phase && !hwrite_in && (haddr_in[31:4] == 28'h0000000)) begin
            hrdata_out <= {24'h000000, read_reg(bus_addr)};
        end else begin
            hrdata_out <= 32'h00000000;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Wake from deep stop, or light stop left by reset, acts as a full reset
    assign soft_reset = !resetn_in || stop_reset_wake_in;

    always_ff @(posedge ref_clk_in) begin
        if (soft_reset) begin
            overflow_irq_en <= RESET_IRQ_EN;
            counter_halt_ctl <= RESET_HALT;
        end else if (wr_status) begin
            overflow_irq_en <= wdata[OVERFLOW_IRQ_EN_BIT];
            counter_halt_ctl <= wdata[COUNTER_HALT_BIT];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (soft_reset) begin
            clock_source_sel <= RESET_CLOCK_SOURCE;
            prescale_sel <= RESET_PRESCALE;
        end else if (wr_clock) begin
            clock_source_sel <= wdata[CLOCK_SOURCE_MSB:CLOCK_SOURCE_LSB];
            prescale_sel <= wdata[PRESCALE_MSB:PRESCALE_LSB];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (soft_reset) begin
            wrap_limit <= RESET_WRAP_LIMIT;
        end else if (wr_modulo) begin
            wrap_limit <= wdata;
        end
    end

    // ----------------------------------------
    // Prescaler and counter
    // ----------------------------------------
    // Stop and debug freeze the prescaler and counter but leave state intact for resume
    assign count_enable = !counter_halt_ctl && !stop_mode_in && !debug_active_in;
    assign counter_clear = (wr_status && wdata[COUNTER_RESET_BIT]) || wr_modulo;

    timer_prescaler #(
        .DIV_WIDTH(8)
    ) prescaler (
        .ref_clk_in(ref_clk_in),
        .resetn_in(!soft_reset),
        .clear_in(counter_clear),
        .enable_in(count_enable),
        .clock_source_sel_in(clock_source_sel),
        .prescale_sel_in(prescale_sel),
        .fixed_freq_clock_in(fixed_freq_clock_in),
        .ext_timer_clock_pin_in(ext_timer_clock_pin_in),
        .tick_out(tick)
    );

    // Tick is a cycle late, so gate it again to stop promptly on halt
    always_comb begin
        if (wrap_limit == 8'h00) begin
            wrap_now = (count_value == COUNT_MAX);
        end else begin
            wrap_now = (count_value == wrap_limit);
        end
    end

    assign next_flag_set = tick && count_enable && !counter_clear && wrap_now;
    assign flag_clear = wr_status && clear_armed && !wdata[OVERFLOW_FLAG_BIT];
    assign next_flag = next_flag_set || (overflow_flag && !flag_clear);
    assign next_irq_en = wr_status ? wdata[OVERFLOW_IRQ_EN_BIT] : overflow_irq_en;

    always_ff @(posedge ref_clk_in) begin
        if (soft_reset) begin
            count_value <= RESET_COUNT;
        end else if (counter_clear) begin
            count_value <= RESET_COUNT;
        end else if (tick && count_enable) begin
            if (wrap_now) begin
                count_value <= RESET_COUNT;
            end else begin
                count_value <= count_value + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Overflow flag and clear sequence
    // ----------------------------------------
    // A new overflow in the clearing cycle wins over the clear
    always_ff @(posedge ref_clk_in) begin
        if (soft_reset) begin
            overflow_flag <= 1'b0;
            clear_armed <= 1'b0;
        end else begin
            if (next_flag_set) begin
                overflow_flag <= 1'b1;
            end else if (flag_clear) begin
                overflow_flag <= 1'b0;
            end
            if (addr_phase && !hwrite_in && bus_addr == ADDR_STATUS_CONTROL
                    && haddr_in[31:4] == 28'h0000000 && overflow_flag) begin
                clear_armed <= 1'b1;
            end else if (wr_status) begin
                clear_armed <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Request is independent of wait mode, so it can wake the processor
    always_ff @(posedge ref_clk_in) begin
        if (soft_reset) begin
            irq_out <= 1'b0;
            count_value_out <= RESET_COUNT;
        end else begin
            // Built from next values so the request drops with the flag clear
            irq_out <= next_flag && next_irq_en;
            count_value_out <= count_value;
        end
    end

endmodule : modulo_timer

//--- tb/modulo_timer_properties.sv
module modulo_timer_properties
    import modulo_timer_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [31:0] hrdata_out,
    input wire logic stop_mode_in,
    input wire logic stop_reset_wake_in,
    input wire logic debug_active_in,
    input wire logic irq_out,
    input wire logic [7:0] count_value_out
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    // Three cycles let the freeze reach the lagging count copy
    sequence seq_dbg_held;
        (debug_active_in && !stop_reset_wake_in && !hsel_in) [*3];
    endsequence
    sequence seq_stop_held;
        (stop_mode_in && !stop_reset_wake_in && !hsel_in) [*3];
    endsequence

    a_ready_high: assert property (hreadyout_out)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp_out)
        else $error("hresp not okay");
    a_rdata_upper: assert property (hrdata_out[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rdata_idle: assert property (!(hsel_in && htrans_in[1] && !hwrite_in && hready_in)
        |=> hrdata_out == 32'h0)
        else $error("read data outside data phase");
    a_count_step: assert property ($changed(count_value_out) |->
        count_value_out == 8'($past(count_value_out) + 8'h01) || count_value_out == 8'h00)
        else $error("count jumped");
    a_debug_freeze: assert property (seq_dbg_held |=> $stable(count_value_out))
        else $error("count moved in debug");
    a_stop_freeze: assert property (seq_stop_held |=> $stable(count_value_out))
        else $error("count moved in stop");
    a_wake_reset: assert property (stop_reset_wake_in |-> ##2
        (count_value_out == 8'h00 && !irq_out))
        else $error("wake did not reset timer");
endmodule : modulo_timer_properties

bind modulo_timer modulo_timer_properties u_props (.ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out), .stop_mode_in(stop_mode_in),
    .stop_reset_wake_in(stop_reset_wake_in), .debug_active_in(debug_active_in),
    .irq_out(irq_out), .count_value_out(count_value_out));

//--- tb/modulo_timer_tb.sv
module modulo_timer_tb
    import modulo_timer_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hsel_in = 1'b0;
    logic hwrite_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [31:0] hwdata_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic fixed_clk = 1'b0;
    logic pin_level = 1'b0;
    logic stop_mode_in = 1'b0;
    logic stop_reset_wake_in = 1'b0;
    logic debug_active_in = 1'b0;
    logic rd_phase = 1'b0;
    logic hreadyout_out;
    logic hresp_out;
    logic [31:0] hrdata_out;
    logic irq_out;
    logic [7:0] count_value_out;
    logic [7:0] exp_q[$];
    logic [7:0] lfsr = 8'h16;
    logic [7:0] m;
    logic [7:0] v;
    int err_count = 0;
    int total_checks = 0;
    int gap;

    modulo_timer dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .hrdata_out(hrdata_out), .fixed_freq_clock_in(fixed_clk),
        .ext_timer_clock_pin_in(pin_level), .stop_mode_in(stop_mode_in),
        .stop_reset_wake_in(stop_reset_wake_in), .debug_active_in(debug_active_in),
        .irq_out(irq_out), .count_value_out(count_value_out));

    // ----------------------------------------
    // Clocks and helpers
    // ----------------------------------------
    initial begin
        forever begin
            #25 ref_clk_in = ~ref_clk_in;
        end
    end
    always begin
        repeat (5) @(posedge ref_clk_in);
        fixed_clk <= ~fixed_clk;
    end
    always begin
        repeat (3) @(posedge ref_clk_in);
        pin_level <= ~pin_level;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task check(input string name, input logic [31:0] e, input logic [31:0] got);
        total_checks++;
        if (got !== e) begin
            $display("MISMATCH %s expected %h seen %h", name, e, got);
            err_count++;
        end
    endtask : check

    task end_sim();
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task bus(input logic wr, input logic hi, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        hsel_in <= 1'b1;
        haddr_in <= {27'h0, hi, a};
        hwrite_in <= wr;
        htrans_in <= 2'h2;
        @(posedge ref_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= {24'h0, d};
        rd_phase <= !wr;
        if (!wr) exp_q.push_back(d);
        @(posedge ref_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
        rd_phase <= 1'b0;
    endtask : bus

    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, 1'b0, a, e);
    endtask : rd

    task settle();
        repeat (2) @(negedge ref_clk_in);
    endtask : settle

    // Sampled at the falling edge so the registered count has settled
    task wait_change();
        logic [7:0] old;
        old = count_value_out;
        gap = 0;
        while (count_value_out === old && gap < 600) begin
            @(negedge ref_clk_in);
            gap++;
        end
    endtask : wait_change

    task run_gap(input int e);
        wr(ADDR_MODULO_LIMIT, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        wait_change();
        wait_change();
        check("tick_gap", e, gap);
    endtask : run_gap

    always @(posedge ref_clk_in) begin
        if (rd_phase) check("hrdata", {24'h0, exp_q.pop_front()}, hrdata_out);
    end

    initial begin
        #(50 * 60000);
        err_count++;
        end_sim();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        rd(ADDR_STATUS_CONTROL, 8'h10);
        rd(ADDR_CLOCK_CONFIG, 8'h00);
        rd(ADDR_COUNT_VALUE, 8'h00);
        rd(ADDR_MODULO_LIMIT, 8'h00);
        bus(1'b0, 1'b1, 4'h0, 8'h00);
        for (int k = 0; k < 3; k++) begin
            lfsr = lfsr_next(lfsr);
            m = {4'h0, lfsr[3:0]} | 8'h02;
            wr(ADDR_MODULO_LIMIT, m);
            wr(ADDR_STATUS_CONTROL, 8'h40);
            v = 8'h00;
            repeat (40) begin
                @(negedge ref_clk_in);
                if (count_value_out > v) v = count_value_out;
            end
            check("count_max", m, v);
            rd(ADDR_MODULO_LIMIT, m);
            wr(ADDR_STATUS_CONTROL, 8'h50);
            settle();
            check("irq_on", 32'h1, 32'(irq_out));
            wr(ADDR_STATUS_CONTROL, 8'h10);
            settle();
            check("irq_off", 32'h0, 32'(irq_out));
            rd(ADDR_STATUS_CONTROL, 8'h90);
            wr(ADDR_STATUS_CONTROL, 8'h10);
            rd(ADDR_STATUS_CONTROL, 8'h10);
        end
        wr(ADDR_COUNT_VALUE, 8'h55);
        wr(ADDR_STATUS_CONTROL, 8'h30);
        rd(ADDR_STATUS_CONTROL, 8'h10);
        rd(ADDR_COUNT_VALUE, 8'h00);
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_CLOCK_CONFIG, (i == 9) ? 8'h0f : 8'(i));
            run_gap((i == 9) ? 256 : (1 << i));
        end
        for (int s = 1; s < 4; s++) begin
            wr(ADDR_CLOCK_CONFIG, 8'(s << 4));
            run_gap((s == 1) ? 10 : 6);
        end
        rd(ADDR_CLOCK_CONFIG, 8'h30);
        wr(ADDR_CLOCK_CONFIG, 8'h00);
        for (int j = 1; j < 3; j++) begin
            @(posedge ref_clk_in);
            {stop_mode_in, debug_active_in} <= 2'(j);
            repeat (3) @(negedge ref_clk_in);
            v = count_value_out;
            repeat (20) @(negedge ref_clk_in);
            check("frozen", v, count_value_out);
            @(posedge ref_clk_in);
            {stop_mode_in, debug_active_in} <= 2'h0;
            wait_change();
            check("resumed", 8'(v + 8'h01), count_value_out);
        end
        wr(ADDR_CLOCK_CONFIG, 8'h25);
        wr(ADDR_MODULO_LIMIT, 8'h07);
        wr(ADDR_STATUS_CONTROL, 8'h40);
        @(posedge ref_clk_in);
        stop_reset_wake_in <= 1'b1;
        @(posedge ref_clk_in);
        stop_reset_wake_in <= 1'b0;
        rd(ADDR_STATUS_CONTROL, 8'h10);
        rd(ADDR_CLOCK_CONFIG, 8'h00);
        rd(ADDR_MODULO_LIMIT, 8'h00);
        rd(ADDR_COUNT_VALUE, 8'h00);
        end_sim();
    end
endmodule : modulo_timer_tb
